// ### src/l2dc_defines.svh
// constants for the level-2 dma coherence controller
// assumes a 32-bit word, one cpu clock domain
`ifndef L2DC_DEFINES_SVH
`define L2DC_DEFINES_SVH

`define L2DC_CFG_RESET       32'h0000_0000
`define L2DC_CFG_PINV_BIT    9
`define L2DC_CFG_DINV_BIT    8
`define L2DC_CFG_MODE_MSB    2
`define L2DC_CFG_MODE_LSB    0
`define L2DC_MODE_0WAY       3'h0
`define L2DC_MODE_1WAY       3'h1
`define L2DC_MODE_2WAY       3'h2
`define L2DC_MODE_3WAY       3'h3
`define L2DC_MODE_4WAY       3'h7
`define L2DC_WAY_KBYTES      7'h10
`define L2DC_LINE_LSB        5
`define L2DC_TRACK_LINES     512
`define L2DC_XFER_MAX        2'h1
`define L2DC_XFER_URGENT     1'b1
`define L2DC_CTRL_BASE       32'h0100_0000
`define L2DC_CTRL_MASK       32'hFFFF_0000
`define L2DC_CFG_ADDR        32'h0100_0000

`endif

// ### src/l2dc_pkg.sv
// types for the level-2 dma coherence controller
// assumes the defines header is compiled alongside
package l2dc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOOK,
    ST_SNOOP,
    ST_SRAM_RD,
    ST_RD_WAIT,
    ST_RESP
  } state_t;

  typedef enum logic [1:0] {
    XK_MISS_FILL,
    XK_VICTIM_WB,
    XK_UNCACHED_RD,
    XK_UNCACHED_WR
  } xfer_kind_t;
endpackage : l2dc_pkg

// ### src/l2dc_track_if.sv
// carrier between the controller and its line tracking record
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface l2dc_track_if #(parameter int IDX_W = 9);
  logic             rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic             rd_bit;
  logic             set_en;
  logic [IDX_W-1:0] set_idx;
  logic             clr_en;
  logic [IDX_W-1:0] clr_idx;

  modport ctrl (output rd_en, output rd_idx, input rd_bit,
                output set_en, output set_idx, output clr_en, output clr_idx);
  modport mem  (input rd_en, input rd_idx, output rd_bit,
                input set_en, input set_idx, input clr_en, input clr_idx);
endinterface : l2dc_track_if

// ### src/l2dc_track_mem.sv
// one bit per sram line: may the level-1 data cache hold a copy
// assumes clock enable gates every update; read data registered
`timescale 1ns/1ps
module l2dc_track_mem #(
  parameter int LINES = 512
) (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  l2dc_track_if.mem   trk
);
  logic [LINES-1:0] bits_q;
  logic             rd_bit_q;
  localparam int    IW = $clog2(LINES);

  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_line
      wire set_hit = trk.set_en && (trk.set_idx == IW'(i));
      wire clr_hit = trk.clr_en && (trk.clr_idx == IW'(i));
      // set wins over a clear in the same cycle
      always_ff @(posedge clk) begin
        if (rst) begin
          bits_q[i] <= 1'b0;
        end else if (ce) begin
          if (set_hit) begin
            bits_q[i] <= 1'b1;
          end else if (clr_hit) begin
            bits_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_bit_q <= 1'b0;
    end else if (ce && trk.rd_en) begin
      rd_bit_q <= bits_q[trk.rd_idx];
    end
  end

  assign trk.rd_bit = rd_bit_q;
endmodule : l2dc_track_mem

// ### src/l2dc_ctrl.sv
// level-2 controller: dma service of sram with level-1 coherence,
// configuration register, and transfer requests to the dma controller
// assumes all neighbours run on CLK; sram read data stands while its enable does
//
// Operation
// - track possible data-cache copy per sram line
// - dma read snoops data cache first when tracked
// - dirty snoop data written, line stays clean
// - dma read sends nothing to program cache
// - dma write outside control register space always invalidates program cache line
// - write snoop-invalidate only when tracked
// - merge snoop data, dma bytes win
// - misses, writebacks, uncached go to dma
// - priority and outstanding limit fixed
// - cpu reads and writes control registers
// - dma control register accesses dropped
// - host port and pci enter through dma
// - bit 9 invalidates whole program cache
// - bit 8 invalidates whole data cache
// - mode field selects zero to four ways
// - mode 0 default, each way 16K
// - reserved bits read zero, written zero
`timescale 1ns/1ps
`include "l2dc_defines.svh"
module l2dc_ctrl #(
  parameter int          TRACK_LINES = `L2DC_TRACK_LINES,
  parameter logic [31:0] CTRL_BASE   = `L2DC_CTRL_BASE,
  parameter logic [31:0] CTRL_MASK   = `L2DC_CTRL_MASK,
  parameter logic [31:0] CFG_ADDR    = `L2DC_CFG_ADDR
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CLK_EN,
  input  wire logic        DMA_REQ_VALID,
  input  wire logic        DMA_REQ_WRITE,
  input  wire logic [31:0] DMA_REQ_ADDR,
  input  wire logic [31:0] DMA_REQ_WDATA,
  input  wire logic [3:0]  DMA_REQ_BE,
  output logic             DMA_REQ_READY,
  output logic             DMA_RSP_VALID,
  output logic [31:0]      DMA_RSP_RDATA,
  input  wire logic        CPU_REG_VALID,
  input  wire logic        CPU_REG_WRITE,
  input  wire logic [31:0] CPU_REG_ADDR,
  input  wire logic [31:0] CPU_REG_WDATA,
  output logic             CPU_REG_ACK,
  output logic [31:0]      CPU_REG_RDATA,
  input  wire logic        L1D_FILL_VALID,
  input  wire logic [31:0] L1D_FILL_ADDR,
  output logic             L1D_SNP_VALID,
  output logic             L1D_SNP_INVAL,
  output logic [31:0]      L1D_SNP_ADDR,
  input  wire logic        L1D_SNP_RSP_VALID,
  input  wire logic        L1D_SNP_RSP_DIRTY,
  input  wire logic [31:0] L1D_SNP_RSP_DATA,
  output logic             L1P_INV_VALID,
  output logic [31:0]      L1P_INV_ADDR,
  output logic             L1P_INV_ALL,
  output logic             L1D_INV_ALL,
  output logic             SRAM_EN,
  output logic             SRAM_WE,
  output logic [31:0]      SRAM_ADDR,
  output logic [31:0]      SRAM_WDATA,
  output logic [3:0]       SRAM_BE,
  input  wire logic [31:0] SRAM_RDATA,
  output logic [2:0]       L2_CACHE_WAYS,
  output logic [6:0]       L2_CACHE_KBYTES,
  input  wire logic        XFER_NEED_VALID,
  input  wire logic [1:0]  XFER_NEED_KIND,
  input  wire logic [31:0] XFER_NEED_ADDR,
  output logic             XFER_NEED_READY,
  output logic             XFER_REQ_VALID,
  output logic [1:0]       XFER_REQ_KIND,
  output logic [31:0]      XFER_REQ_ADDR,
  output logic             XFER_REQ_URGENT,
  input  wire logic        XFER_REQ_ACCEPT,
  input  wire logic        XFER_DONE
);
  localparam int          IDX_W    = $clog2(TRACK_LINES);
  localparam logic [1:0]  XFER_MAX = `L2DC_XFER_MAX;

  l2dc_pkg::state_t state_q;
  l2dc_pkg::state_t state_d;

  l2dc_track_if #(.IDX_W(IDX_W)) trk ();

  l2dc_track_mem #(.LINES(TRACK_LINES)) u_track (
    .clk (CLK),
    .rst (SYS_RST),
    .ce  (CLK_EN),
    .trk (trk)
  );

  // request held for the whole service
  logic        wr_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [3:0]  be_q;
  logic        ctrl_hit_q;

  // decode
  wire        dma_take    = DMA_REQ_VALID && DMA_REQ_READY;
  wire        dma_ctrl    = (DMA_REQ_ADDR & CTRL_MASK) == CTRL_BASE;
  wire        snp_done    = (state_q == l2dc_pkg::ST_SNOOP) && L1D_SNP_RSP_VALID;
  wire [IDX_W-1:0] req_idx  = DMA_REQ_ADDR[`L2DC_LINE_LSB +: IDX_W];
  wire [IDX_W-1:0] hold_idx = addr_q[`L2DC_LINE_LSB +: IDX_W];
  wire [IDX_W-1:0] fill_idx = L1D_FILL_ADDR[`L2DC_LINE_LSB +: IDX_W];
  wire [31:0] merged;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_merge
      assign merged[8*b +: 8] = be_q[b] ? wdata_q[8*b +: 8]
                                        : L1D_SNP_RSP_DATA[8*b +: 8];
    end
  endgenerate

  // tracking record hookup
  assign trk.rd_en   = dma_take && !dma_ctrl;
  assign trk.rd_idx  = req_idx;
  assign trk.set_en  = L1D_FILL_VALID;
  assign trk.set_idx = fill_idx;
  assign trk.clr_en  = snp_done && wr_q;
  assign trk.clr_idx = hold_idx;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      l2dc_pkg::ST_IDLE: begin
        if (dma_take) begin
          state_d = dma_ctrl ? l2dc_pkg::ST_RESP : l2dc_pkg::ST_LOOK;
        end
      end
      l2dc_pkg::ST_LOOK: begin
        if (trk.rd_bit) begin
          state_d = l2dc_pkg::ST_SNOOP;
        end else begin
          state_d = wr_q ? l2dc_pkg::ST_RESP : l2dc_pkg::ST_RD_WAIT;
        end
      end
      l2dc_pkg::ST_SNOOP: begin
        if (L1D_SNP_RSP_VALID) begin
          if (wr_q) begin
            state_d = l2dc_pkg::ST_RESP;
          end else begin
            state_d = L1D_SNP_RSP_DIRTY ? l2dc_pkg::ST_SRAM_RD : l2dc_pkg::ST_RD_WAIT;
          end
        end
      end
      l2dc_pkg::ST_SRAM_RD: state_d = l2dc_pkg::ST_RD_WAIT;
      l2dc_pkg::ST_RD_WAIT: state_d = l2dc_pkg::ST_RESP;
      l2dc_pkg::ST_RESP:    state_d = l2dc_pkg::ST_IDLE;
    endcase
  end

  // sram port decode
  wire look_clean   = (state_q == l2dc_pkg::ST_LOOK) && !trk.rd_bit;
  wire sram_rd_now  = (look_clean && !wr_q)
                   || (snp_done && !wr_q && !L1D_SNP_RSP_DIRTY)
                   || (state_q == l2dc_pkg::ST_SRAM_RD);
  wire sram_wr_now  = (look_clean && wr_q)
                   || (snp_done && (wr_q || L1D_SNP_RSP_DIRTY));
  wire [31:0] sram_wdata_d = !snp_done ? wdata_q
                           : (wr_q ? merged : L1D_SNP_RSP_DATA);
  wire [3:0]  sram_be_d    = (snp_done && L1D_SNP_RSP_DIRTY) ? 4'hF : be_q;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q       <= l2dc_pkg::ST_IDLE;
      DMA_REQ_READY <= 1'b0;
      wr_q          <= 1'b0;
      addr_q        <= 32'h0000_0000;
      wdata_q       <= 32'h0000_0000;
      be_q          <= 4'h0;
      ctrl_hit_q    <= 1'b0;
    end else if (CLK_EN) begin
      state_q       <= state_d;
      DMA_REQ_READY <= (state_d == l2dc_pkg::ST_IDLE) && !dma_take;
      if (dma_take) begin
        wr_q       <= DMA_REQ_WRITE;
        addr_q     <= DMA_REQ_ADDR;
        wdata_q    <= DMA_REQ_WDATA;
        be_q       <= DMA_REQ_BE;
        ctrl_hit_q <= dma_ctrl;
      end
    end
  end

  // coherence commands
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      L1P_INV_VALID <= 1'b0;
      L1P_INV_ADDR  <= 32'h0000_0000;
      L1D_SNP_VALID <= 1'b0;
      L1D_SNP_INVAL <= 1'b0;
      L1D_SNP_ADDR  <= 32'h0000_0000;
    end else if (CLK_EN) begin
      L1P_INV_VALID <= dma_take && DMA_REQ_WRITE && !dma_ctrl;
      if (dma_take) begin
        L1P_INV_ADDR <= DMA_REQ_ADDR;
      end
      if ((state_q == l2dc_pkg::ST_LOOK) && trk.rd_bit) begin
        L1D_SNP_VALID <= 1'b1;
        L1D_SNP_INVAL <= wr_q;
        L1D_SNP_ADDR  <= addr_q;
      end else if (L1D_SNP_RSP_VALID) begin
        L1D_SNP_VALID <= 1'b0;
      end
    end
  end

  // sram port and dma answer
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SRAM_EN       <= 1'b0;
      SRAM_WE       <= 1'b0;
      SRAM_ADDR     <= 32'h0000_0000;
      SRAM_WDATA    <= 32'h0000_0000;
      SRAM_BE       <= 4'h0;
      DMA_RSP_VALID <= 1'b0;
      DMA_RSP_RDATA <= 32'h0000_0000;
    end else if (CLK_EN) begin
      SRAM_EN       <= sram_rd_now || sram_wr_now;
      SRAM_WE       <= sram_wr_now;
      SRAM_ADDR     <= addr_q;
      SRAM_WDATA    <= sram_wdata_d;
      SRAM_BE       <= sram_wr_now ? sram_be_d : 4'hF;
      DMA_RSP_VALID <= state_d == l2dc_pkg::ST_RESP;
      if (state_q == l2dc_pkg::ST_RD_WAIT) begin
        DMA_RSP_RDATA <= SRAM_RDATA;
      end else if (state_q == l2dc_pkg::ST_IDLE) begin
        DMA_RSP_RDATA <= 32'h0000_0000;
      end
    end
  end

  // configuration register
  logic       pinv_q;
  logic       dinv_q;
  logic [2:0] mode_q;
  wire        cfg_sel  = CPU_REG_VALID && (CPU_REG_ADDR == CFG_ADDR);
  wire        cfg_wr   = cfg_sel && CPU_REG_WRITE;
  wire [2:0]  mode_in  = CPU_REG_WDATA[`L2DC_CFG_MODE_MSB:`L2DC_CFG_MODE_LSB];
  wire        mode_ok  = (mode_in <= `L2DC_MODE_3WAY) || (mode_in == `L2DC_MODE_4WAY);
  wire [2:0]  ways_d   = (mode_q == `L2DC_MODE_4WAY) ? 3'h4 : mode_q;
  wire [31:0] cfg_view = {22'h00_0000, pinv_q, dinv_q, 5'h00, mode_q};

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pinv_q          <= 1'(`L2DC_CFG_RESET >> `L2DC_CFG_PINV_BIT);
      dinv_q          <= 1'b0;
      mode_q          <= `L2DC_MODE_0WAY;
      L1P_INV_ALL     <= 1'b0;
      L1D_INV_ALL     <= 1'b0;
      CPU_REG_ACK     <= 1'b0;
      CPU_REG_RDATA   <= 32'h0000_0000;
      L2_CACHE_WAYS   <= 3'h0;
      L2_CACHE_KBYTES <= 7'h00;
    end else if (CLK_EN) begin
      pinv_q      <= cfg_wr && CPU_REG_WDATA[`L2DC_CFG_PINV_BIT];
      dinv_q      <= cfg_wr && CPU_REG_WDATA[`L2DC_CFG_DINV_BIT];
      L1P_INV_ALL <= cfg_wr && CPU_REG_WDATA[`L2DC_CFG_PINV_BIT];
      L1D_INV_ALL <= cfg_wr && CPU_REG_WDATA[`L2DC_CFG_DINV_BIT];
      if (cfg_wr && mode_ok) begin
        mode_q <= mode_in;
      end
      CPU_REG_ACK     <= CPU_REG_VALID;
      CPU_REG_RDATA   <= cfg_sel ? cfg_view : 32'h0000_0000;
      L2_CACHE_WAYS   <= ways_d;
      L2_CACHE_KBYTES <= 7'(ways_d * `L2DC_WAY_KBYTES);
    end
  end

  // transfer requests toward the dma controller
  logic [1:0] outst_q;
  wire        need_take = XFER_NEED_VALID && XFER_NEED_READY;
  wire        req_acc   = XFER_REQ_VALID && XFER_REQ_ACCEPT;
  wire [1:0]  outst_d   = 2'(outst_q + {1'b0, req_acc} - {1'b0, XFER_DONE && outst_q != 2'h0});
  wire        reqv_d    = need_take || (XFER_REQ_VALID && !req_acc);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      outst_q         <= 2'h0;
      XFER_REQ_VALID  <= 1'b0;
      XFER_REQ_KIND   <= 2'h0;
      XFER_REQ_ADDR   <= 32'h0000_0000;
      XFER_NEED_READY <= 1'b0;
      XFER_REQ_URGENT <= `L2DC_XFER_URGENT;
    end else if (CLK_EN) begin
      outst_q         <= outst_d;
      XFER_REQ_VALID  <= reqv_d;
      XFER_NEED_READY <= !reqv_d && (outst_d < XFER_MAX);
      XFER_REQ_URGENT <= `L2DC_XFER_URGENT;
      if (need_take) begin
        XFER_REQ_KIND <= XFER_NEED_KIND;
        XFER_REQ_ADDR <= XFER_NEED_ADDR;
      end
    end
  end

  // checks
  default clocking cb @(posedge CLK iff CLK_EN); endclocking
  default disable iff (SYS_RST);

  sequence s_rd_taken;
    dma_take && !DMA_REQ_WRITE && !dma_ctrl;
  endsequence
  sequence s_wr_taken;
    dma_take && DMA_REQ_WRITE && !dma_ctrl;
  endsequence

  AST_RD_NO_L1P: assert property (s_rd_taken |=> !L1P_INV_VALID [*3])
    else $error("program cache command on dma read");
  AST_WR_L1P: assert property (s_wr_taken |=>
      L1P_INV_VALID && L1P_INV_ADDR == $past(DMA_REQ_ADDR))
    else $error("dma write did not invalidate program cache");
  AST_SNP_TRACKED: assert property ((state_q == l2dc_pkg::ST_LOOK)
      |=> L1D_SNP_VALID == $past(trk.rd_bit))
    else $error("data cache snoop does not follow tracking");
  AST_RD_WAITS_SNP: assert property (L1D_SNP_VALID && !L1D_SNP_INVAL
      |-> !DMA_RSP_VALID ##1 !DMA_RSP_VALID)
    else $error("dma read answered before snoop done");
  AST_DIRTY_WB: assert property (snp_done && !wr_q && L1D_SNP_RSP_DIRTY
      |=> SRAM_WE && SRAM_BE == 4'hF && SRAM_WDATA == $past(L1D_SNP_RSP_DATA)
      ##1 SRAM_EN && !SRAM_WE)
    else $error("dirty snoop data not written before read");
  AST_MERGE: assert property (snp_done && wr_q && L1D_SNP_RSP_DIRTY
      |=> SRAM_WE && SRAM_WDATA == $past(merged) && SRAM_BE == 4'hF)
    else $error("merged write data wrong");
  AST_HOLD_WR: assert property (state_q == l2dc_pkg::ST_SNOOP
      && !L1D_SNP_RSP_VALID |=> !SRAM_WE)
    else $error("sram written before snoop response");
  AST_CTRL_DROP: assert property (dma_take && dma_ctrl
      |=> ctrl_hit_q && DMA_RSP_VALID && DMA_RSP_RDATA == 32'h0000_0000 && !SRAM_EN
      ##1 !SRAM_EN)
    else $error("dma control register access not dropped");
  AST_RSVD_ZERO: assert property (CPU_REG_ACK |->
      CPU_REG_RDATA[31:10] == 22'h00_0000 && CPU_REG_RDATA[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  AST_PINV: assert property (cfg_wr && CPU_REG_WDATA[9] |=> L1P_INV_ALL
      ##1 !L1P_INV_ALL || $past(cfg_wr))
    else $error("program cache invalidate-all pulse wrong");
  AST_XFER_MAX: assert property (outst_q <= XFER_MAX)
    else $error("too many outstanding transfers");
endmodule : l2dc_ctrl

// ### tb/l2dc_far_model.sv
// far-side model: level-1 caches, l2 sram array, dma transfer engine
// assumes CLK shared with the controller; drives just after the rising edge
`timescale 1ns/1ps
module l2dc_far_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        dirty,
  input  wire logic [2:0]  snp_wait,
  input  wire logic        snp_valid,
  output logic             snp_rsp,
  output logic             snp_dirty,
  output logic [31:0]      snp_data,
  input  wire logic        sram_en,
  input  wire logic        sram_we,
  input  wire logic [31:0] sram_addr,
  input  wire logic [31:0] sram_wdata,
  input  wire logic [3:0]  sram_be,
  output logic [31:0]      sram_rdata,
  input  wire logic        xreq_valid,
  output logic             xreq_accept,
  output logic             xfer_done
);
  localparam logic [31:0] DIRTY_WORD = 32'hA5A5_5A5A;
  logic [31:0] mem [64];
  logic [2:0]  sc;
  logic        served;
  logic [2:0]  xc;
  initial for (int i = 0; i < 64; i++) mem[i] = 32'h1000_0000 + i;
  assign snp_dirty = snp_rsp ? dirty : ~dirty;
  assign snp_data  = snp_rsp ? DIRTY_WORD : ~DIRTY_WORD;
  // read data shows while the read enable stands, the inverse otherwise
  assign sram_rdata = (sram_en && !sram_we) ? mem[sram_addr[7:2]] : ~mem[sram_addr[7:2]];
  always @(posedge clk) begin
    if (sram_en && sram_we) begin
      for (int b = 0; b < 4; b++)
        if (sram_be[b]) mem[sram_addr[7:2]][8*b+:8] <= sram_wdata[8*b+:8];
    end
    // data cache drops or cleans its line and answers once per snoop
    snp_rsp <= #1 1'b0;
    if (rst || !snp_valid) begin
      sc     <= 3'h0;
      served <= 1'b0;
    end else if (!served) begin
      sc <= sc + 3'h1;
      if (sc == snp_wait) begin
        snp_rsp <= #1 1'b1;
        served  <= 1'b1;
      end
    end
    // urgent queue: accept then finish, one request at a time
    xreq_accept <= #1 1'b0;
    xfer_done   <= #1 1'b0;
    if (rst) xc <= 3'h0;
    else if (xc != 3'h0 || xreq_valid) begin
      xc <= (xc == 3'h5) ? 3'h0 : xc + 3'h1;
      if (xc == 3'h2) xreq_accept <= #1 1'b1;
      if (xc == 3'h5) xfer_done <= #1 1'b1;
    end
  end
  // program-cache invalidates get no answer: no input back from it
endmodule : l2dc_far_model

// ### tb/tb_top.sv
// self-checking bench for the level-2 dma coherence controller
// assumes default parameters and the far-side model
`timescale 1ns/1ps
`include "l2dc_defines.svh"
module tb_top;
  logic CLK = 0, SYS_RST = 1, dv = 0, dw = 0, cv = 0, cw = 0, fv = 0, nv = 0;
  logic [31:0] da = 0, dd = 0, ca = 0, cd = 0, fa = 0, na = 0, rd;
  logic [3:0]  dbe = 0;
  logic [1:0]  nk = 0;
  logic dirty = 0;
  logic [2:0] sw = 0;
  int error_cnt = 0, n_checks = 0, n_snp, n_pinv, n_swr;
  logic snp_inv, sv_q = 0;
  logic [1:0] pls;
  logic [31:0] pinv_a, swr_d, snp_a, swr_a;
  logic [3:0] swr_be;
  wire rdy, rv, ack, sv, si, pv, pall, dall, se, swe, nr, xv, xu, sr, sdt, xa, xd;
  wire [31:0] rdat, crd, sa, pa, sad, swd, srd, xad, sdat;
  wire [3:0] sbe;
  wire [2:0] ways;
  wire [6:0] kb;
  wire [1:0] xk;
  always #5 CLK = ~CLK;
  l2dc_ctrl u_l2dc_ctrl (.CLK(CLK), .SYS_RST(SYS_RST), .CLK_EN(1'b1),
    .DMA_REQ_VALID(dv), .DMA_REQ_WRITE(dw), .DMA_REQ_ADDR(da), .DMA_REQ_WDATA(dd),
    .DMA_REQ_BE(dbe), .DMA_REQ_READY(rdy), .DMA_RSP_VALID(rv), .DMA_RSP_RDATA(rdat),
    .CPU_REG_VALID(cv), .CPU_REG_WRITE(cw), .CPU_REG_ADDR(ca), .CPU_REG_WDATA(cd),
    .CPU_REG_ACK(ack), .CPU_REG_RDATA(crd), .L1D_FILL_VALID(fv), .L1D_FILL_ADDR(fa),
    .L1D_SNP_VALID(sv), .L1D_SNP_INVAL(si), .L1D_SNP_ADDR(sa), .L1D_SNP_RSP_VALID(sr),
    .L1D_SNP_RSP_DIRTY(sdt), .L1D_SNP_RSP_DATA(sdat), .L1P_INV_VALID(pv),
    .L1P_INV_ADDR(pa), .L1P_INV_ALL(pall), .L1D_INV_ALL(dall), .SRAM_EN(se),
    .SRAM_WE(swe), .SRAM_ADDR(sad), .SRAM_WDATA(swd), .SRAM_BE(sbe), .SRAM_RDATA(srd),
    .L2_CACHE_WAYS(ways), .L2_CACHE_KBYTES(kb), .XFER_NEED_VALID(nv),
    .XFER_NEED_KIND(nk), .XFER_NEED_ADDR(na), .XFER_NEED_READY(nr),
    .XFER_REQ_VALID(xv), .XFER_REQ_KIND(xk), .XFER_REQ_ADDR(xad),
    .XFER_REQ_URGENT(xu), .XFER_REQ_ACCEPT(xa), .XFER_DONE(xd));
  l2dc_far_model u_l2dc_far_model (.clk(CLK), .rst(SYS_RST), .dirty(dirty),
    .snp_wait(sw), .snp_valid(sv), .snp_rsp(sr), .snp_dirty(sdt), .snp_data(sdat),
    .sram_en(se), .sram_we(swe), .sram_addr(sad), .sram_wdata(swd), .sram_be(sbe),
    .sram_rdata(srd), .xreq_valid(xv), .xreq_accept(xa), .xfer_done(xd));
  // event monitors on the coherence and sram sides
  always @(posedge CLK) begin
    sv_q <= sv;
    if (sv && !sv_q) begin n_snp++; snp_inv = si; snp_a = sa; end
    if (pv) begin n_pinv++; pinv_a = pa; end
    if (se && swe) begin n_swr++; swr_d = swd; swr_be = sbe; swr_a = sad; end
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic clr();
    n_snp = 0; n_pinv = 0; n_swr = 0;
  endtask : clr
  // 32-bit register access from the cpu side
  task automatic reg_acc(input logic w, input logic [31:0] a, input logic [31:0] d);
    cv = 1; cw = w; ca = a; cd = d;
    @(posedge CLK); #1;
    cv = 0;
    chk(ack, 1, "ack");
    rd = crd;
    pls = {pall, dall};
    @(posedge CLK); #1;
  endtask : reg_acc
  task automatic dma(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 50) begin @(posedge CLK); #1; n++; end
    dv = 1; dw = w; da = a; dd = d; dbe = be;
    @(posedge CLK); #1;
    dv = 0;
    while (rv !== 1'b1 && n < 100) begin @(posedge CLK); #1; n++; end
    chk(n < 100, 1, "dma rsp");
    rd = rdat;
    @(posedge CLK); #1;
  endtask : dma
  task automatic fill(input logic [31:0] a);
    fv = 1; fa = a;
    @(posedge CLK); #1;
    fv = 0;
  endtask : fill
  task automatic t_reset();
    chk({rdy, nr, xu, ways, kb}, {3'b111, 10'h0}, "reset outputs");
    reg_acc(0, `L2DC_CFG_ADDR, 0);
    chk(rd, `L2DC_CFG_RESET, "cfg reset");
    $display("test reset done");
  endtask : t_reset
  task automatic t_cfg();
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    reg_acc(1, `L2DC_CFG_ADDR, 32'h0000_0302);
    chk(pls, 2'b11, "inv all pulses");
    chk({pall, dall, ways, kb}, {2'b00, 3'h2, 7'h20}, "mode 2");
    for (int i = 0; i < 5; i++) begin
      reg_acc(1, `L2DC_CFG_ADDR, {29'h0, codes[i]});
      chk({ways, kb}, {i[2:0], i[6:0] * 7'h10}, "ways");
    end
    reg_acc(1, `L2DC_CFG_ADDR, 32'h0000_0005);
    reg_acc(0, `L2DC_CFG_ADDR, 0);
    chk(rd, 32'h7, "reserved code");
    reg_acc(1, `L2DC_CFG_ADDR, 32'hFFFF_FCF9);
    reg_acc(0, `L2DC_CFG_ADDR, 0);
    chk(rd, 32'h1, "reserved bits");
    reg_acc(0, `L2DC_CFG_ADDR + 32'h4, 0);
    chk(rd, 32'h0, "unmapped");
    $display("test cfg done");
  endtask : t_cfg
  task automatic t_plain();
    clr();
    dma(1, 32'h80, 32'hCAFE_0001, 4'h5);
    chk({n_pinv, n_snp, n_swr}, {32'd1, 32'd0, 32'd1}, "untracked wr");
    chk(pinv_a, 32'h80, "pinv addr");
    chk({swr_d, 28'h0, swr_be}, {32'hCAFE_0001, 32'h5}, "sram wr");
    chk(swr_a, 32'h80, "sram addr");
    clr();
    dma(0, 32'h80, 0, 4'hF);
    chk(rd, 32'h10FE_0001, "rd back");
    chk({n_pinv, n_snp}, 0, "rd no cmds");
    $display("test plain done");
  endtask : t_plain
  task automatic t_snoop();
    dirty = 1; sw = 3'h4;
    fill(32'h100);
    clr();
    dma(0, 32'h100, 0, 4'hF);
    chk({n_snp, 31'h0, snp_inv, n_pinv}, {32'd1, 32'd0, 32'd0}, "rd snoop");
    chk(snp_a, 32'h100, "snoop addr");
    chk({swr_d, swr_be}, {32'hA5A5_5A5A, 4'hF}, "dirty wb");
    chk(rd, 32'hA5A5_5A5A, "rd fresh");
    sw = 3'h1;
    fill(32'h200);
    clr();
    dma(1, 32'h200, 32'h1111_2222, 4'h3);
    chk({n_snp, 31'h0, snp_inv}, {32'd1, 32'd1}, "wr snoop");
    chk({swr_d, swr_be}, {32'hA5A5_2222, 4'hF}, "merge");
    clr();
    dma(1, 32'h200, 32'h3333_4444, 4'hF);
    chk({n_snp, swr_d}, {32'd0, 32'h3333_4444}, "untracked after inv");
    dirty = 0;
    fill(32'h300);
    clr();
    dma(0, 32'h300, 0, 4'hF);
    chk({n_snp, n_swr, rd}, {32'd1, 32'd0, 32'h3333_4444}, "clean snoop rd");
    $display("test snoop done");
  endtask : t_snoop
  task automatic t_ctrl();
    clr();
    dma(1, `L2DC_CFG_ADDR, 32'h3, 4'hF);
    dma(0, `L2DC_CFG_ADDR, 0, 4'hF);
    chk(rd, 32'h0, "dropped rd");
    chk({n_swr, n_snp, n_pinv}, 0, "no activity");
    reg_acc(0, `L2DC_CFG_ADDR, 0);
    chk(rd, 32'h1, "cfg kept");
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_xfer();
    int n;
    for (int k = 0; k < 4; k++) begin
      nv = 1; nk = k[1:0]; na = 32'h8000_0000 + k;
      @(posedge CLK); #1;
      nv = 0;
      chk({xv, xu, nr, xk, xad}, {3'b110, k[1:0], 32'h8000_0000 + k}, "xfer");
      n = 0;
      while (nr !== 1'b1 && n < 20) begin
        chk(nr, 0, "one outstanding");
        @(posedge CLK); #1; n++;
      end
      chk(n < 20, 1, "xfer done");
    end
    $display("test xfer done");
  endtask : t_xfer
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    #100000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (8) @(posedge CLK);
    #1 SYS_RST = 0;
    repeat (2) @(posedge CLK);
    #1;
    t_reset();
    t_cfg();
    t_plain();
    t_snoop();
    t_ctrl();
    t_xfer();
    results();
  end
endmodule : tb_top
